// file: inc/pps_pkg.sv
// Contract
// - supervisor holds reset low 5 ms after supplies
// - park request high before reset release
// - reference clock stable within 5 ms of power
// - reset released under 1 ms after clock; the host starts the clock with the supplies, about 5.5 ms before release
// - reset rising edge starts auto-initialization
// - boot takes typically 100 ms
// - setup 2.75 ms, commands accepted after
// - companion ready typically 1.5 s after reset
// - interrupt low when init done, commands open
// - firmware loaded from flash at startup, on demand
// - host issues commands, controller acts on them
// - power request high means on, low off
// - host stops commands before dropping power request
// - falling request: park, reset, supplies off, power off
// - mirrors parked within 20 ms of request fall
// - supplies and clock held 20 ms after fall
// - system power kept at least 50 ms after fall
// - reset releases interrupt line to pull-up
// - core power loss floats host-side outputs
// - init locks pll then loads flash config
// - request not lowered before interrupt goes low
// - after fast park keep clock, reset 32 us
package pps_pkg;
    localparam int unsigned CLK_HZ         = 10_000_000;
    localparam int unsigned RST_HOLD_US    = 5000;   // supervisor reset hold after supplies
    localparam int unsigned CLK_LEAD_US    = 1000;   // clock to reset release, typical maximum
    localparam int unsigned BOOT_US        = 100000; // controller boot
    localparam int unsigned SETUP_NS       = 2750000; // companion register setup
    localparam int unsigned PARK_MAX_US    = 20000;  // park limit after request fall
    localparam int unsigned SUPPLY_HOLD_US = 20000;  // supplies and clock hold after fall
    localparam int unsigned SYSTEM_SUPPLY_HOLD_US = 50000;  // system supply hold after fall
    localparam int unsigned FPARK_US       = 32;     // fast-park hold
    localparam int unsigned PLL_LOCK_US    = 100;    // pll lock time
    localparam int unsigned CYC_PER_US     = CLK_HZ / 1_000_000;
    localparam int unsigned RST_HOLD_CYC    = RST_HOLD_US * CYC_PER_US;
    localparam int unsigned CLK_LEAD_CYC    = CLK_LEAD_US * CYC_PER_US / 2;
    localparam int unsigned BOOT_CYC        = BOOT_US * CYC_PER_US;
    localparam int unsigned SETUP_CYC       = (SETUP_NS * 1 + 99) / 100;
    localparam int unsigned PARK_CYC        = PARK_MAX_US * CYC_PER_US / 2;
    localparam int unsigned SUPPLY_HOLD_CYC = SUPPLY_HOLD_US * CYC_PER_US;
    localparam int unsigned SYSTEM_SUPPLY_HOLD_CYC = SYSTEM_SUPPLY_HOLD_US * CYC_PER_US;
    localparam int unsigned FPARK_CYC       = FPARK_US * CYC_PER_US;
    localparam int unsigned PLL_LOCK_CYC    = PLL_LOCK_US * CYC_PER_US;
    localparam int          CNT_W           = 24;
    localparam logic [1:0]  FLASH_BOOT      = 2'h1;
    localparam logic [1:0]  FLASH_RELOAD    = 2'h2;

    typedef enum logic [2:0] {
        PPS_D_OFF     = 3'h0,
        PPS_D_PLL     = 3'h1,
        PPS_D_BOOT    = 3'h3,
        PPS_D_SETUP   = 3'h2,
        PPS_D_READY   = 3'h6,
        PPS_D_PARK    = 3'h7,
        PPS_D_PARKED  = 3'h5
    } pps_dev_state_t;

    typedef enum logic [2:0] {
        PPS_H_IDLE    = 3'h0,
        PPS_H_SUPPLY  = 3'h1,
        PPS_H_CLKWAIT = 3'h3,
        PPS_H_INIT    = 3'h2,
        PPS_H_RUN     = 3'h6,
        PPS_H_DOWN    = 3'h7,
        PPS_H_HOLD    = 3'h5,
        PPS_H_FPARK   = 3'h4
    } pps_host_state_t;
endpackage : pps_pkg

// file: inc/pps_if.sv
`timescale 1ns/1ps
// pins between the controller and the host/power manager
interface pps_if;
    logic reset_in_n;         // from supervisor
    logic fast_park_req_n;    // early power-loss warning
    logic power_on_request;   // projector on/off
    logic clk_ref_en;         // reference clock running
    logic host_io_supply;     // i/o rail present
    logic core_supply;        // core rail present
    logic system_supply;      // main input power present
    logic irq_o;              // interrupt driven value
    logic irq_oe;             // interrupt driver enable
    logic irq_line;           // resolved level, pull-up when undriven
    logic cmd_valid;          // host command strobe
    logic [7:0] cmd_data;     // host command byte
    logic cmd_ready;          // controller accepts commands
    logic parked;             // mirrors parked

    assign irq_line = irq_oe ? irq_o : 1'b1;

    modport dev (
        input  reset_in_n, fast_park_req_n, power_on_request, clk_ref_en,
        input  host_io_supply, core_supply, cmd_valid, cmd_data,
        output irq_o, irq_oe, cmd_ready, parked
    );
    modport host (
        output reset_in_n, fast_park_req_n, power_on_request, clk_ref_en,
        output host_io_supply, core_supply, system_supply, cmd_valid, cmd_data,
        input  irq_line, cmd_ready, parked
    );
endinterface : pps_if

// file: hdl/pps_device.sv
`timescale 1ns/1ps
// controller end: init sequencing, command gating, parking
module pps_device #(
    parameter int unsigned BOOT_CYC  = pps_pkg::BOOT_CYC,
    parameter int unsigned SETUP_CYC = pps_pkg::SETUP_CYC,
    parameter int unsigned PARK_CYC  = pps_pkg::PARK_CYC,
    parameter int unsigned PLL_CYC   = pps_pkg::PLL_LOCK_CYC
) (
    input  wire logic       mclk,
    input  wire logic       nrst,
    pps_if.dev              pins,
    input  wire logic       pll_locked,
    input  wire logic       flash_done,
    input  wire logic       reload_req,
    output logic [1:0]      flash_load,
    output logic            fpga_setup,
    output logic [7:0]      cmd_out,
    output logic            cmd_out_valid,
    output logic            display_on
);
    pps_pkg::pps_dev_state_t state_reg;
    logic [pps_pkg::CNT_W-1:0] cnt_reg;
    logic rst_q_reg;
    logic on_q_reg;
    logic fpark_q_reg;
    logic alive;

    assign alive = pins.core_supply && pins.reset_in_n;

    // sequencing; a rising reset edge restarts from pll lock
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg   <= pps_pkg::PPS_D_OFF;
            cnt_reg     <= '0;
            rst_q_reg   <= 1'b0;
            on_q_reg    <= 1'b0;
            fpark_q_reg <= 1'b1;
        end else begin
            rst_q_reg   <= pins.reset_in_n;
            on_q_reg    <= pins.power_on_request;
            fpark_q_reg <= pins.fast_park_req_n;
            if (!alive) begin
                state_reg <= pps_pkg::PPS_D_OFF;
                cnt_reg   <= '0;
            end else begin
                case (state_reg)
                    pps_pkg::PPS_D_OFF: begin
                        // park request must already be high at release
                        if (!rst_q_reg && pins.fast_park_req_n) begin
                            state_reg <= pps_pkg::PPS_D_PLL;
                            cnt_reg   <= '0;
                        end
                    end
                    pps_pkg::PPS_D_PLL: begin
                        cnt_reg <= cnt_reg + 1'b1;
                        if (pll_locked && cnt_reg >= PLL_CYC[pps_pkg::CNT_W-1:0]) begin
                            state_reg <= pps_pkg::PPS_D_BOOT;
                            cnt_reg   <= '0;
                        end
                    end
                    pps_pkg::PPS_D_BOOT: begin
                        cnt_reg <= cnt_reg + 1'b1;
                        if (flash_done && cnt_reg >= BOOT_CYC[pps_pkg::CNT_W-1:0]) begin
                            state_reg <= pps_pkg::PPS_D_SETUP;
                            cnt_reg   <= '0;
                        end
                    end
                    pps_pkg::PPS_D_SETUP: begin
                        cnt_reg <= cnt_reg + 1'b1;
                        if (cnt_reg >= SETUP_CYC[pps_pkg::CNT_W-1:0]) begin
                            state_reg <= pps_pkg::PPS_D_READY;
                            cnt_reg   <= '0;
                        end
                    end
                    pps_pkg::PPS_D_READY: begin
                        // falling request or fast park both lead to parking
                        if ((on_q_reg && !pins.power_on_request) || !pins.fast_park_req_n) begin
                            state_reg <= pps_pkg::PPS_D_PARK;
                            cnt_reg   <= '0;
                        end
                    end
                    pps_pkg::PPS_D_PARK: begin
                        cnt_reg <= cnt_reg + 1'b1;
                        // fast park finishes within the short hold window
                        if (cnt_reg >= (fpark_q_reg ? PARK_CYC[pps_pkg::CNT_W-1:0] - 1'b1
                                        : pps_pkg::FPARK_CYC[pps_pkg::CNT_W-1:0] / 2)) begin
                            state_reg <= pps_pkg::PPS_D_PARKED;
                        end
                    end
                    pps_pkg::PPS_D_PARKED: state_reg <= pps_pkg::PPS_D_PARKED; // wait for reset
                    default: state_reg <= pps_pkg::PPS_D_OFF;
                endcase
            end
        end
    end

    // flash loads: boot image in boot phase, reloads while running
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            flash_load <= 2'h0;
        end else if (state_reg == pps_pkg::PPS_D_BOOT) begin
            flash_load <= pps_pkg::FLASH_BOOT;
        end else if (state_reg == pps_pkg::PPS_D_READY && reload_req) begin
            flash_load <= pps_pkg::FLASH_RELOAD;
        end else begin
            flash_load <= 2'h0;
        end
    end

    // command intake only once setup is done
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cmd_out       <= 8'h00;
            cmd_out_valid <= 1'b0;
        end else begin
            cmd_out_valid <= pins.cmd_valid && pins.cmd_ready;
            if (pins.cmd_valid && pins.cmd_ready) begin
                cmd_out <= pins.cmd_data;
            end
        end
    end

    // status outputs from the state register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            fpga_setup <= 1'b0;
            display_on <= 1'b0;
            pins.parked <= 1'b0;
        end else begin
            fpga_setup  <= alive && state_reg == pps_pkg::PPS_D_SETUP;
            display_on  <= alive && state_reg == pps_pkg::PPS_D_READY && pins.power_on_request;
            pins.parked <= state_reg == pps_pkg::PPS_D_PARKED;
        end
    end

    // irq: high while initializing, low when done, released in reset or core loss
    assign pins.irq_oe    = alive && pins.host_io_supply && state_reg != pps_pkg::PPS_D_OFF;
    assign pins.irq_o     = !(state_reg == pps_pkg::PPS_D_READY || state_reg == pps_pkg::PPS_D_PARK
                              || state_reg == pps_pkg::PPS_D_PARKED);
    assign pins.cmd_ready = alive && state_reg == pps_pkg::PPS_D_READY;
endmodule : pps_device

// file: hdl/pps_host.sv
`timescale 1ns/1ps
// host and power manager end: supplies, reset, power request, commands
module pps_host #(
    parameter int unsigned RST_HOLD_CYC    = pps_pkg::RST_HOLD_CYC,
    parameter int unsigned CLK_LEAD_CYC    = pps_pkg::CLK_LEAD_CYC,
    parameter int unsigned SYSTEM_SUPPLY_HOLD_CYC = pps_pkg::SYSTEM_SUPPLY_HOLD_CYC,
    parameter int unsigned SUPPLY_HOLD_CYC = pps_pkg::SUPPLY_HOLD_CYC,
    parameter int unsigned FPARK_CYC       = pps_pkg::FPARK_CYC
) (
    input  wire logic       mclk,
    input  wire logic       nrst,
    pps_if.host             pins,
    input  wire logic       power_switch,
    input  wire logic       power_fail,
    input  wire logic       cmd_req,
    input  wire logic [7:0] cmd_byte,
    output logic            cmd_busy,
    output logic            host_ready
);
    pps_pkg::pps_host_state_t state_reg;
    logic [pps_pkg::CNT_W-1:0] cnt_reg;

    // sequencing of supplies, clock, reset and power request
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= pps_pkg::PPS_H_IDLE;
            cnt_reg   <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
            // fast park only once reset is up; a fault earlier must not release reset
            if (power_fail && state_reg inside {pps_pkg::PPS_H_INIT, pps_pkg::PPS_H_RUN,
                                                pps_pkg::PPS_H_DOWN}) begin
                state_reg <= pps_pkg::PPS_H_FPARK;
                cnt_reg   <= '0;
            end else if (power_fail && state_reg inside {pps_pkg::PPS_H_SUPPLY,
                         pps_pkg::PPS_H_CLKWAIT}) begin
                state_reg <= pps_pkg::PPS_H_IDLE;
            end else begin
                case (state_reg)
                    pps_pkg::PPS_H_IDLE: if (power_switch && !power_fail) begin
                        state_reg <= pps_pkg::PPS_H_SUPPLY;
                        cnt_reg   <= '0;
                    end
                    pps_pkg::PPS_H_SUPPLY: if (cnt_reg >= RST_HOLD_CYC[pps_pkg::CNT_W-1:0]) begin
                        state_reg <= pps_pkg::PPS_H_CLKWAIT;
                        cnt_reg   <= '0;
                    end
                    pps_pkg::PPS_H_CLKWAIT: if (cnt_reg >= CLK_LEAD_CYC[pps_pkg::CNT_W-1:0]) begin
                        state_reg <= pps_pkg::PPS_H_INIT;
                    end
                    // no fixed timer: wait for interrupt low, request held
                    pps_pkg::PPS_H_INIT: if (!pins.irq_line && pins.reset_in_n) begin
                        state_reg <= pps_pkg::PPS_H_RUN;
                    end
                    pps_pkg::PPS_H_RUN: if (!power_switch && !cmd_req) begin
                        state_reg <= pps_pkg::PPS_H_DOWN;
                        cnt_reg   <= '0;
                    end
                    pps_pkg::PPS_H_DOWN: if (pins.parked && cnt_reg >= SUPPLY_HOLD_CYC[pps_pkg::CNT_W-1:0]) begin
                        state_reg <= pps_pkg::PPS_H_HOLD;
                    end
                    pps_pkg::PPS_H_HOLD: if (cnt_reg >= SYSTEM_SUPPLY_HOLD_CYC[pps_pkg::CNT_W-1:0]) begin
                        state_reg <= pps_pkg::PPS_H_IDLE;
                    end
                    pps_pkg::PPS_H_FPARK: if (cnt_reg >= FPARK_CYC[pps_pkg::CNT_W-1:0]) begin
                        state_reg <= pps_pkg::PPS_H_IDLE;
                    end
                    default: state_reg <= pps_pkg::PPS_H_IDLE;
                endcase
            end
        end
    end

    // pin drive decoded from state, registered; i/o supply and clock follow core supply one cycle later
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pins.reset_in_n       <= 1'b0;
            pins.fast_park_req_n  <= 1'b1;
            pins.power_on_request <= 1'b0;
            pins.clk_ref_en       <= 1'b0;
            pins.host_io_supply   <= 1'b0;
            pins.core_supply      <= 1'b0;
            pins.system_supply    <= 1'b0;
        end else begin
            pins.system_supply    <= state_reg != pps_pkg::PPS_H_IDLE;
            pins.core_supply      <= state_reg inside {pps_pkg::PPS_H_SUPPLY, pps_pkg::PPS_H_CLKWAIT,
                                     pps_pkg::PPS_H_INIT, pps_pkg::PPS_H_RUN, pps_pkg::PPS_H_DOWN,
                                     pps_pkg::PPS_H_FPARK};
            pins.host_io_supply   <= pins.core_supply;
            pins.clk_ref_en       <= pins.core_supply;
            pins.fast_park_req_n  <= state_reg != pps_pkg::PPS_H_FPARK;
            pins.reset_in_n       <= state_reg inside {pps_pkg::PPS_H_INIT, pps_pkg::PPS_H_RUN,
                                     pps_pkg::PPS_H_DOWN, pps_pkg::PPS_H_FPARK};
            pins.power_on_request <= state_reg inside {pps_pkg::PPS_H_SUPPLY,
                                     pps_pkg::PPS_H_CLKWAIT, pps_pkg::PPS_H_INIT,
                                     pps_pkg::PPS_H_RUN};
        end
    end

    // command forwarding only while running and the controller accepts
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pins.cmd_valid <= 1'b0;
            pins.cmd_data  <= 8'h00;
        end else begin
            pins.cmd_valid <= cmd_req && state_reg == pps_pkg::PPS_H_RUN && pins.cmd_ready;
            pins.cmd_data  <= cmd_byte;
        end
    end

    assign cmd_busy   = cmd_req && !(state_reg == pps_pkg::PPS_H_RUN && pins.cmd_ready);
    assign host_ready = state_reg == pps_pkg::PPS_H_RUN;
endmodule : pps_host

// file: verif/pps_properties.sv
`timescale 1ns/1ps
// watches the pins between the two ends; counters stand in for the long waits
module pps_properties #(
    parameter int PLL_CYC         = pps_pkg::PLL_LOCK_CYC,
    parameter int BOOT_CYC        = pps_pkg::BOOT_CYC,
    parameter int SETUP_CYC       = pps_pkg::SETUP_CYC,
    parameter int PARK_CYC        = pps_pkg::PARK_CYC,
    parameter int RST_HOLD_CYC    = pps_pkg::RST_HOLD_CYC,
    parameter int SUPPLY_HOLD_CYC = pps_pkg::SUPPLY_HOLD_CYC,
    parameter int SYSTEM_SUPPLY_HOLD_CYC = pps_pkg::SYSTEM_SUPPLY_HOLD_CYC,
    parameter int FPARK_CYC       = pps_pkg::FPARK_CYC
) (
    input logic mclk,
    input logic nrst,
    input logic reset_in_n,
    input logic fast_park_req_n,
    input logic power_on_request,
    input logic clk_ref_en,
    input logic host_io_supply,
    input logic core_supply,
    input logic system_supply,
    input logic irq_o,
    input logic irq_oe,
    input logic irq_line,
    input logic cmd_valid,
    input logic cmd_ready,
    input logic parked
);
    localparam int PARK_LIM = PARK_CYC + 4;
    logic [15:0] sup_cnt;
    logic [15:0] init_cnt;
    logic [15:0] down_cnt;
    logic [15:0] fp_cnt;

    // saturating step so a long idle spell cannot wrap a counter
    function automatic logic [15:0] step(input logic [15:0] v);
        return (v == 16'hffff) ? v : v + 16'h1;
    endfunction : step

    // cycles since supplies up, init in progress, request low, fast park low
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sup_cnt  <= 16'h0;
            init_cnt <= 16'h0;
            down_cnt <= 16'h0;
            fp_cnt   <= 16'h0;
        end else begin
            sup_cnt  <= (core_supply && host_io_supply) ? step(sup_cnt) : 16'h0;
            init_cnt <= !reset_in_n ? 16'h0 : (irq_line ? step(init_cnt) : init_cnt);
            down_cnt <= power_on_request ? 16'h0 : step(down_cnt);
            fp_cnt   <= fast_park_req_n ? 16'h0 : step(fp_cnt);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_release;
        $rose(reset_in_n);
    endsequence
    sequence s_normal_off;
        $fell(power_on_request) && fast_park_req_n;
    endsequence

    a_hold_reset: assert property (s_release |-> sup_cnt >= RST_HOLD_CYC && $past(clk_ref_en))
        else $error("reset released too early");
    a_park_first: assert property (s_release |-> fast_park_req_n)
        else $error("reset released with fast park low");
    a_init_length: assert property ($fell(irq_line) && reset_in_n |-> init_cnt >= PLL_CYC + BOOT_CYC + SETUP_CYC)
        else $error("init done too early");
    a_ready_irq: assert property (cmd_ready |-> irq_oe && !irq_o)
        else $error("commands open without interrupt low");
    a_irq_released: assert property (!reset_in_n [*3] |-> !irq_oe)
        else $error("interrupt driven during reset");
    a_cmd_gate: assert property (cmd_valid |-> cmd_ready)
        else $error("command sent before ready");
    a_stop_first: assert property (s_normal_off |-> $past(irq_line) == 1'b0 && !$past(cmd_valid))
        else $error("request dropped too soon");
    a_park_limit: assert property (s_normal_off |-> ##[1:PARK_LIM] parked)
        else $error("mirrors not parked in time");
    a_park_before_reset: assert property ($fell(reset_in_n) |-> $past(parked))
        else $error("reset before park");
    a_supply_hold: assert property (($fell(core_supply) || $fell(clk_ref_en)) && fast_park_req_n && !power_on_request |-> down_cnt >= SUPPLY_HOLD_CYC)
        else $error("supply or clock dropped early");
    a_system_supply_hold: assert property ($fell(system_supply) && fast_park_req_n && !power_on_request |-> down_cnt >= SYSTEM_SUPPLY_HOLD_CYC)
        else $error("system supply dropped early");
    // park request returns high on the same edge that reset drops, so look one sample back
    a_fpark_hold: assert property (($fell(reset_in_n) || $fell(clk_ref_en)) && !$past(fast_park_req_n) |-> fp_cnt >= FPARK_CYC)
        else $error("fast park window cut short");
endmodule : pps_properties

// file: verif/testbench.sv
`timescale 1ns/1ps
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; $display("[FAIL] %s expected %0h seen %0h", what, exp, got); end end
module testbench;
    // shortened counts keep the run small
    localparam int PLL_C = 5, BOOT_C = 50, SETUP_C = 20, PARK_C = 30, HOLD_C = 10;
    // controller fast park is fixed at half the full window, so the host keeps all of it
    localparam int LEAD_C = 5, SYS_C = 60, SUP_C = 40, FP_C = pps_pkg::FPARK_CYC, RDY_C = 60;
    logic       mclk = 1'b0, nrst = 1'b0, power_switch = 1'b0, power_fail = 1'b0;
    logic       cmd_req = 1'b0, pll_locked = 1'b0, flash_done = 1'b0, reload_req = 1'b0;
    logic [7:0] cmd_byte = 8'h00, cmd_out;
    logic [1:0] flash_load;
    logic       fpga_setup, cmd_out_valid, display_on, cmd_busy, host_ready;
    logic       setup_seen = 1'b0, early_cmd = 1'b0;
    int         n_mismatch = 0, n_checks = 0, cyc = 0, t_mark = 0, rdy_cnt = 0;
    pps_if link ();
    pps_device #(.BOOT_CYC(BOOT_C), .SETUP_CYC(SETUP_C), .PARK_CYC(PARK_C), .PLL_CYC(PLL_C))
        i_pps_device (.mclk(mclk), .nrst(nrst), .pins(link), .pll_locked(pll_locked),
        .flash_done(flash_done), .reload_req(reload_req), .flash_load(flash_load),
        .fpga_setup(fpga_setup), .cmd_out(cmd_out), .cmd_out_valid(cmd_out_valid),
        .display_on(display_on));
    pps_host #(.RST_HOLD_CYC(HOLD_C), .CLK_LEAD_CYC(LEAD_C), .SYSTEM_SUPPLY_HOLD_CYC(SYS_C),
        .SUPPLY_HOLD_CYC(SUP_C), .FPARK_CYC(FP_C))
        i_pps_host (.mclk(mclk), .nrst(nrst), .pins(link), .power_switch(power_switch),
        .power_fail(power_fail), .cmd_req(cmd_req), .cmd_byte(cmd_byte), .cmd_busy(cmd_busy),
        .host_ready(host_ready));
    pps_properties #(.PLL_CYC(PLL_C), .BOOT_CYC(BOOT_C), .SETUP_CYC(SETUP_C), .PARK_CYC(PARK_C),
        .RST_HOLD_CYC(HOLD_C), .SUPPLY_HOLD_CYC(SUP_C), .SYSTEM_SUPPLY_HOLD_CYC(SYS_C), .FPARK_CYC(FP_C))
        i_pps_properties (.mclk(mclk), .nrst(nrst), .reset_in_n(link.reset_in_n),
        .fast_park_req_n(link.fast_park_req_n), .power_on_request(link.power_on_request),
        .clk_ref_en(link.clk_ref_en), .host_io_supply(link.host_io_supply),
        .core_supply(link.core_supply), .system_supply(link.system_supply), .irq_o(link.irq_o),
        .irq_oe(link.irq_oe), .irq_line(link.irq_line), .cmd_valid(link.cmd_valid),
        .cmd_ready(link.cmd_ready), .parked(link.parked));

    always #50 mclk = ~mclk;
    // flash stand-in answers any load request on the next falling edge
    always @(negedge mclk) flash_done <= (flash_load != 2'h0);
    // sticky monitors: setup phase seen, command leaking out before init done
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        // companion stand-in: ready a fixed count after its reset is released
        rdy_cnt <= (link.reset_in_n === 1'b1) ? rdy_cnt + 1 : 0;
        if (fpga_setup === 1'b1) setup_seen <= 1'b1;
        if (cmd_out_valid === 1'b1 && link.irq_line !== 1'b0) early_cmd <= 1'b1;
    end

    function automatic logic hit(input int k);
        case (k)
            0: return link.irq_line === 1'b0;
            1: return flash_load === pps_pkg::FLASH_BOOT;
            2: return cmd_out_valid === 1'b1;
            3: return link.parked === 1'b1;
            4: return link.system_supply === 1'b0;
            5: return flash_load === pps_pkg::FLASH_RELOAD;
            6: return link.reset_in_n === 1'b0;
            7: return link.reset_in_n === 1'b1;
            default: return cmd_busy === 1'b0;
        endcase
    endfunction : hit

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // bounded wait polled on falling edges; running out ends the run
    task automatic wait_until(input int k, input int lim);
        for (int i = 0; i < lim && !hit(k); i++) @(negedge mclk);
        if (!hit(k)) begin
            n_mismatch++;
            $display("[FAIL] wait %0d expected 1 seen 0", k);
            test_done();
        end
    endtask : wait_until

    // the request is held until the host accepts it, then the byte is checked at the controller
    task automatic send_cmd(input logic [7:0] b);
        cmd_byte = b;
        cmd_req = 1'b1;
        wait_until(8, 40);
        // one edge with the host accepting, then the request comes down: one byte per call
        @(negedge mclk);
        cmd_req = 1'b0;
        wait_until(2, 40);
        `CHK("cmd byte", b, cmd_out)
        @(negedge mclk);
    endtask : send_cmd

    initial begin
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        nrst = 1'b1;
        // power up with a command already waiting and the pll held off
        power_switch = 1'b1;
        cmd_byte = 8'h5a;
        cmd_req = 1'b1;
        wait_until(7, 200);
        t_mark = cyc;
        repeat (20) @(negedge mclk);
        `CHK("flash before lock", 2'h0, flash_load)
        `CHK("irq during init", 1'b1, link.irq_line)
        `CHK("cmd held", 1'b1, cmd_busy)
        pll_locked = 1'b1;
        wait_until(1, 50);
        wait_until(0, 400);
        // host state and display flag follow the interrupt one edge later
        @(negedge mclk);
        `CHK("init length", 1'b1, (cyc - t_mark) >= PLL_C + BOOT_C + SETUP_C)
        `CHK("companion ready", 1'b1, rdy_cnt >= RDY_C)
        `CHK("setup seen", 1'b1, setup_seen)
        `CHK("cmd ready", 1'b1, link.cmd_ready)
        `CHK("host ready", 1'b1, host_ready)
        `CHK("display on", 1'b1, display_on)
        send_cmd(8'h5a);
        `CHK("early cmd", 1'b0, early_cmd)
        $display("test power_up done");
        // back-to-back commands with edge values, then a reload
        send_cmd(8'h00);
        send_cmd(8'hff);
        send_cmd(8'h3c);
        reload_req = 1'b1;
        wait_until(5, 40);
        reload_req = 1'b0;
        $display("test commands done");
        // normal power-down
        power_switch = 1'b0;
        t_mark = cyc;
        wait_until(3, PARK_C + 20);
        `CHK("park time", 1'b1, (cyc - t_mark) <= PARK_C + 8)
        `CHK("display off", 1'b0, display_on)
        wait_until(6, 100);
        repeat (3) @(negedge mclk);
        `CHK("irq released", 1'b1, link.irq_line)
        wait_until(4, SYS_C + 40);
        `CHK("power hold", 1'b1, (cyc - t_mark) >= SYS_C)
        $display("test power_down done");
        // power up again, then lose input power
        power_switch = 1'b1;
        wait_until(0, 600);
        power_fail = 1'b1;
        t_mark = cyc;
        repeat (3) @(negedge mclk);
        `CHK("fast park low", 1'b0, link.fast_park_req_n)
        `CHK("reset still high", 1'b1, link.reset_in_n)
        wait_until(6, FP_C + 30);
        `CHK("fast park window", 1'b1, (cyc - t_mark) >= FP_C)
        repeat (3) @(negedge mclk);
        `CHK("irq after fault", 1'b1, link.irq_line)
        $display("test fast_park done");
        test_done();
    end
endmodule : testbench
